// ==== tvio_pkg.sv ====
// tvio_pkg: constants and register map of the tv mcu port block
// Overview of operation
// - first port lines: input, pulled input, output
// - first port 4..7 open-drain, no pull-up
// - first port 0..3 drive push-pull
// - second port six lines, 0-2, 4-6
// - third port all open-drain; 4..7 no pull-up
// - third port 0,1,3 AND serial drive
// - line 0 clock, 1 data, 3 enable
// - lines 4,6 feed programmable edge interrupt latches
// - reset holds oscillator off, restarts program
package tvio_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_PA_DATA  = 8'h00;
	localparam logic [7:0] OFS_PA_DIR   = 8'h01;
	localparam logic [7:0] OFS_PA_PULL  = 8'h02;
	localparam logic [7:0] OFS_PB_DATA  = 8'h03;
	localparam logic [7:0] OFS_PB_DIR   = 8'h04;
	localparam logic [7:0] OFS_PB_PULL  = 8'h05;
	localparam logic [7:0] OFS_PC_DATA  = 8'h06;
	localparam logic [7:0] OFS_PC_DIR   = 8'h07;
	localparam logic [7:0] OFS_PC_PULL  = 8'h08;
	localparam logic [7:0] OFS_PA_PINS  = 8'h09;
	localparam logic [7:0] OFS_PB_PINS  = 8'h0a;
	localparam logic [7:0] OFS_PC_PINS  = 8'h0b;
	localparam logic [7:0] OFS_EDGE_CFG = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0d;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h0e;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h0f;

	// ****************************************
	// reset values and line masks
	// ****************************************
	localparam logic [7:0] DATA_RST    = 8'h00;
	localparam logic [7:0] DIR_RST     = 8'h00;
	localparam logic [7:0] PULL_RST    = 8'h00;
	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [7:0] PA_OD_MASK  = 8'hf0;
	localparam logic [7:0] PA_PU_MASK  = 8'h0f;
	localparam logic [7:0] PB_LN_MASK  = 8'h77;
	localparam logic [7:0] PC_PU_MASK  = 8'h0f;
	localparam logic [7:0] PC_SER_MASK = 8'h0b;

	// ****************************************
	// field positions
	// ****************************************
	localparam int PC_SCL_BIT   = 0;
	localparam int PC_SDA_BIT   = 1;
	localparam int PC_SEN_BIT   = 3;
	localparam int PC_PWR_BIT   = 4;
	localparam int PC_RMT_BIT   = 6;
	localparam int CFG_PWR_EN   = 0;
	localparam int CFG_PWR_RISE = 1;
	localparam int CFG_RMT_EN   = 2;
	localparam int CFG_RMT_RISE = 3;
	localparam int IRQ_PWR_BIT  = 0;
	localparam int IRQ_RMT_BIT  = 1;
	localparam int IRQ_W        = 2;

	// ****************************************
	// timing counts
	// ****************************************
	localparam logic [1:0] EDGE_WARM = 2'h3;

endpackage : tvio_pkg

// ==== tvio_edge_if.sv ====
// tvio_edge_if: one edge latch channel between the port block and its latch
`timescale 1ns/1ps
`default_nettype none
interface tvio_edge_if;
	logic level;
	logic enable;
	logic rising;
	logic hit;
	modport latch (input level, input enable, input rising, output hit);
	modport owner (output level, output enable, output rising, input hit);
endinterface : tvio_edge_if
`default_nettype wire

// ==== tvio_sync.sv ====
// tvio_sync: two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module tvio_sync #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : tvio_sync
`default_nettype wire

// ==== tvio_edge_latch.sv ====
// tvio_edge_latch: programmable edge detector feeding one interrupt latch
`timescale 1ns/1ps
`default_nettype none
module tvio_edge_latch (
	input  wire logic core_clk,
	input  wire logic reset,
	tvio_edge_if.latch ev
);
	logic       prev_reg;
	logic       hit_reg;
	logic [1:0] warm_reg;

	// sync stages refill from zero after reset while the pin idles high;
	// edges inside this window are dropped so no false edge is latched
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			warm_reg <= 2'h0;
		end else if (warm_reg != tvio_pkg::EDGE_WARM) begin
			warm_reg <= warm_reg + 2'h1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= ev.level;
		end
	end

	// rising or falling chosen by software; disabled latch stays quiet
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hit_reg <= 1'b0;
		end else if (warm_reg != tvio_pkg::EDGE_WARM) begin
			hit_reg <= 1'b0;
		end else if (ev.rising) begin
			hit_reg <= ev.enable & ev.level & ~prev_reg;
		end else begin
			hit_reg <= ev.enable & ~ev.level & prev_reg;
		end
	end

	assign ev.hit = hit_reg;
endmodule : tvio_edge_latch
`default_nettype wire

// ==== tvio_ports.sv ====
// tvio_ports: three general purpose ports, serial pin sharing, edge interrupts
`timescale 1ns/1ps
`default_nettype none
module tvio_ports (
	input  wire logic       core_clk,
	input  wire logic       reset,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// first port
	input  wire logic [7:0] first_port_lines_in,
	output var  logic [7:0] first_port_lines_out,
	output var  logic [7:0] first_port_lines_oe,
	output var  logic [7:0] first_port_lines_pull_en,
	// second port, bits 3 and 7 absent
	input  wire logic [7:0] second_port_lines_in,
	output var  logic [7:0] second_port_lines_out,
	output var  logic [7:0] second_port_lines_oe,
	output var  logic [7:0] second_port_lines_pull_en,
	// third port
	input  wire logic [7:0] third_port_lines_in,
	output var  logic [7:0] third_port_lines_out,
	output var  logic [7:0] third_port_lines_oe,
	output var  logic [7:0] third_port_lines_pull_en,
	// serial interface drive levels and pin sense
	input  wire logic       serial_clock_drive,
	input  wire logic       serial_data_drive,
	input  wire logic       serial_enable_line_drive,
	output var  logic       serial_clock_sense,
	output var  logic       serial_data_sense,
	output var  logic       serial_enable_line_sense,
	// interrupts
	output var  logic       power_event_interrupt,
	output var  logic       remote_input_interrupt,
	output logic            irq,
	// core control
	output var  logic       osc_enable,
	output var  logic       program_restart
);

	// ****************************************
	// reset sequencing
	// ****************************************
	typedef enum logic [2:0] {
		RS_HOLD  = 3'b001,
		RS_START = 3'b010,
		RS_RUN   = 3'b100
	} tvio_rst_e;

	tvio_rst_e rst_state_reg;
	tvio_rst_e rst_state_next;

	always_comb begin
		case (rst_state_reg)
			RS_HOLD:  rst_state_next = RS_START;
			RS_START: rst_state_next = RS_RUN;
			RS_RUN:   rst_state_next = RS_RUN;
			default:  rst_state_next = RS_HOLD;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rst_state_reg <= RS_HOLD;
		end else begin
			rst_state_reg <= rst_state_next;
		end
	end

	// oscillator stays off for as long as reset is held
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			osc_enable      <= 1'b0;
			program_restart <= 1'b0;
		end else begin
			osc_enable      <= 1'b1;
			program_restart <= (rst_state_reg == RS_HOLD);
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	logic [7:0] pa_data_reg;
	logic [7:0] pa_dir_reg;
	logic [7:0] pa_pull_reg;
	logic [7:0] pb_data_reg;
	logic [7:0] pb_dir_reg;
	logic [7:0] pb_pull_reg;
	logic [7:0] pc_data_reg;
	logic [7:0] pc_dir_reg;
	logic [7:0] pc_pull_reg;
	logic [7:0] edge_cfg_reg;
	logic [tvio_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [tvio_pkg::IRQ_W-1:0] irq_en_reg;

	logic wr_pa_data;
	logic wr_pa_dir;
	logic wr_pa_pull;
	logic wr_pb_data;
	logic wr_pb_dir;
	logic wr_pb_pull;
	logic wr_pc_data;
	logic wr_pc_dir;
	logic wr_pc_pull;
	logic wr_cfg;
	logic wr_clr;
	logic wr_en;

	assign wr_pa_data = reg_wr && (reg_addr == tvio_pkg::OFS_PA_DATA);
	assign wr_pa_dir  = reg_wr && (reg_addr == tvio_pkg::OFS_PA_DIR);
	assign wr_pa_pull = reg_wr && (reg_addr == tvio_pkg::OFS_PA_PULL);
	assign wr_pb_data = reg_wr && (reg_addr == tvio_pkg::OFS_PB_DATA);
	assign wr_pb_dir  = reg_wr && (reg_addr == tvio_pkg::OFS_PB_DIR);
	assign wr_pb_pull = reg_wr && (reg_addr == tvio_pkg::OFS_PB_PULL);
	assign wr_pc_data = reg_wr && (reg_addr == tvio_pkg::OFS_PC_DATA);
	assign wr_pc_dir  = reg_wr && (reg_addr == tvio_pkg::OFS_PC_DIR);
	assign wr_pc_pull = reg_wr && (reg_addr == tvio_pkg::OFS_PC_PULL);
	assign wr_cfg     = reg_wr && (reg_addr == tvio_pkg::OFS_EDGE_CFG);
	assign wr_clr     = reg_wr && (reg_addr == tvio_pkg::OFS_IRQ_CLR);
	assign wr_en      = reg_wr && (reg_addr == tvio_pkg::OFS_IRQ_EN);

	// first port: every line may be input or output; only lines 0..3 may be pulled inputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pa_data_reg <= tvio_pkg::DATA_RST;
			pa_dir_reg  <= tvio_pkg::DIR_RST;
			pa_pull_reg <= tvio_pkg::PULL_RST;
		end else begin
			if (wr_pa_data) begin
				pa_data_reg <= reg_wdata;
			end
			if (wr_pa_dir) begin
				pa_dir_reg <= reg_wdata;
			end
			if (wr_pa_pull) begin
				pa_pull_reg <= reg_wdata & tvio_pkg::PA_PU_MASK;
			end
		end
	end

	// second port: absent positions hold zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pb_data_reg <= tvio_pkg::DATA_RST;
			pb_dir_reg  <= tvio_pkg::DIR_RST;
			pb_pull_reg <= tvio_pkg::PULL_RST;
		end else begin
			if (wr_pb_data) begin
				pb_data_reg <= reg_wdata & tvio_pkg::PB_LN_MASK;
			end
			if (wr_pb_dir) begin
				pb_dir_reg <= reg_wdata & tvio_pkg::PB_LN_MASK;
			end
			if (wr_pb_pull) begin
				pb_pull_reg <= reg_wdata & tvio_pkg::PB_LN_MASK;
			end
		end
	end

	// third port: pull-up only on the low nibble
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pc_data_reg <= tvio_pkg::DATA_RST;
			pc_dir_reg  <= tvio_pkg::DIR_RST;
			pc_pull_reg <= tvio_pkg::PULL_RST;
		end else begin
			if (wr_pc_data) begin
				pc_data_reg <= reg_wdata;
			end
			if (wr_pc_dir) begin
				pc_dir_reg <= reg_wdata;
			end
			if (wr_pc_pull) begin
				pc_pull_reg <= reg_wdata & tvio_pkg::PC_PU_MASK;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			edge_cfg_reg <= tvio_pkg::CFG_RST;
			irq_en_reg   <= '0;
		end else begin
			if (wr_cfg) begin
				edge_cfg_reg <= {4'h0, reg_wdata[3:0]};
			end
			if (wr_en) begin
				irq_en_reg <= reg_wdata[tvio_pkg::IRQ_W-1:0];
			end
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [7:0] pa_pins;
	logic [7:0] pb_pins;
	logic [7:0] pc_pins;

	tvio_sync #(.W(8)) u_sync_pa (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (first_port_lines_in),
		.sync_out (pa_pins)
	);

	tvio_sync #(.W(8)) u_sync_pb (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (second_port_lines_in),
		.sync_out (pb_pins)
	);

	tvio_sync #(.W(8)) u_sync_pc (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (third_port_lines_in),
		.sync_out (pc_pins)
	);

	// serial block sees the real wire level, including other drivers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			serial_clock_sense       <= 1'b1;
			serial_data_sense        <= 1'b1;
			serial_enable_line_sense <= 1'b1;
		end else begin
			serial_clock_sense       <= pc_pins[tvio_pkg::PC_SCL_BIT];
			serial_data_sense        <= pc_pins[tvio_pkg::PC_SDA_BIT];
			serial_enable_line_sense <= pc_pins[tvio_pkg::PC_SEN_BIT];
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	logic [7:0] pc_level;

	// shared lines set as outputs pull low if either the port or the serial block says low
	always_comb begin
		pc_level = pc_data_reg;
		pc_level[tvio_pkg::PC_SCL_BIT] = pc_data_reg[tvio_pkg::PC_SCL_BIT]
			& serial_clock_drive;
		pc_level[tvio_pkg::PC_SDA_BIT] = pc_data_reg[tvio_pkg::PC_SDA_BIT]
			& serial_data_drive;
		pc_level[tvio_pkg::PC_SEN_BIT] = pc_data_reg[tvio_pkg::PC_SEN_BIT]
			& serial_enable_line_drive;
	end

	// open-drain lines only ever drive low; release means high-z
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			first_port_lines_out <= 8'h00;
			first_port_lines_oe  <= 8'h00;
		end else begin
			first_port_lines_out <= pa_data_reg & ~tvio_pkg::PA_OD_MASK;
			first_port_lines_oe  <= (pa_dir_reg & ~tvio_pkg::PA_OD_MASK)
				| (pa_dir_reg & ~pa_data_reg & tvio_pkg::PA_OD_MASK);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			second_port_lines_out <= 8'h00;
			second_port_lines_oe  <= 8'h00;
		end else begin
			second_port_lines_out <= pb_data_reg & tvio_pkg::PB_LN_MASK;
			second_port_lines_oe  <= pb_dir_reg & tvio_pkg::PB_LN_MASK;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			third_port_lines_out <= 8'h00;
			third_port_lines_oe  <= 8'h00;
		end else begin
			third_port_lines_out <= 8'h00;
			third_port_lines_oe  <= pc_dir_reg & ~pc_level;
		end
	end

	// pull-ups act only on lines that are inputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			first_port_lines_pull_en  <= 8'h00;
			second_port_lines_pull_en <= 8'h00;
			third_port_lines_pull_en  <= 8'h00;
		end else begin
			first_port_lines_pull_en  <= pa_pull_reg & ~pa_dir_reg
				& tvio_pkg::PA_PU_MASK;
			second_port_lines_pull_en <= pb_pull_reg & ~pb_dir_reg
				& tvio_pkg::PB_LN_MASK;
			third_port_lines_pull_en  <= pc_pull_reg & ~pc_dir_reg
				& tvio_pkg::PC_PU_MASK;
		end
	end

	// ****************************************
	// edge latches and interrupts
	// ****************************************
	tvio_edge_if pwr_ev ();
	tvio_edge_if rmt_ev ();

	assign pwr_ev.level  = pc_pins[tvio_pkg::PC_PWR_BIT];
	assign pwr_ev.enable = edge_cfg_reg[tvio_pkg::CFG_PWR_EN];
	assign pwr_ev.rising = edge_cfg_reg[tvio_pkg::CFG_PWR_RISE];
	assign rmt_ev.level  = pc_pins[tvio_pkg::PC_RMT_BIT];
	assign rmt_ev.enable = edge_cfg_reg[tvio_pkg::CFG_RMT_EN];
	assign rmt_ev.rising = edge_cfg_reg[tvio_pkg::CFG_RMT_RISE];

	tvio_edge_latch u_pwr_latch (
		.core_clk (core_clk),
		.reset    (reset),
		.ev       (pwr_ev.latch)
	);

	tvio_edge_latch u_rmt_latch (
		.core_clk (core_clk),
		.reset    (reset),
		.ev       (rmt_ev.latch)
	);

	logic [tvio_pkg::IRQ_W-1:0] irq_hit;
	logic [tvio_pkg::IRQ_W-1:0] irq_clr;

	always_comb begin
		irq_hit = '0;
		irq_hit[tvio_pkg::IRQ_PWR_BIT] = pwr_ev.hit;
		irq_hit[tvio_pkg::IRQ_RMT_BIT] = rmt_ev.hit;
		irq_clr = wr_clr ? reg_wdata[tvio_pkg::IRQ_W-1:0] : '0;
	end

	// a new edge in the clearing cycle survives the clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_hit;
		end
	end

	assign power_event_interrupt  = irq_stat_reg[tvio_pkg::IRQ_PWR_BIT];
	assign remote_input_interrupt = irq_stat_reg[tvio_pkg::IRQ_RMT_BIT];
	assign irq = |(irq_stat_reg & irq_en_reg);

	// ****************************************
	// read port
	// ****************************************
	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr)
			tvio_pkg::OFS_PA_DATA:  rd_mux = pa_data_reg;
			tvio_pkg::OFS_PA_DIR:   rd_mux = pa_dir_reg;
			tvio_pkg::OFS_PA_PULL:  rd_mux = pa_pull_reg;
			tvio_pkg::OFS_PB_DATA:  rd_mux = pb_data_reg;
			tvio_pkg::OFS_PB_DIR:   rd_mux = pb_dir_reg;
			tvio_pkg::OFS_PB_PULL:  rd_mux = pb_pull_reg;
			tvio_pkg::OFS_PC_DATA:  rd_mux = pc_data_reg;
			tvio_pkg::OFS_PC_DIR:   rd_mux = pc_dir_reg;
			tvio_pkg::OFS_PC_PULL:  rd_mux = pc_pull_reg;
			tvio_pkg::OFS_PA_PINS:  rd_mux = pa_pins;
			tvio_pkg::OFS_PB_PINS:  rd_mux = pb_pins & tvio_pkg::PB_LN_MASK;
			tvio_pkg::OFS_PC_PINS:  rd_mux = pc_pins;
			tvio_pkg::OFS_EDGE_CFG: rd_mux = edge_cfg_reg;
			tvio_pkg::OFS_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
			tvio_pkg::OFS_IRQ_EN:   rd_mux = {6'h00, irq_en_reg};
			default:                rd_mux = 8'h00;
		endcase
	end

	// data valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

endmodule : tvio_ports
`default_nettype wire

// ==== tvio_board.sv ====
// tvio_board: board side of the port pins, resolving each wire's level
`timescale 1ns/1ps
`default_nettype none
module tvio_board (
	input  wire logic [7:0] dev_out,
	input  wire logic [7:0] dev_oe,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_oe,
	output var  logic [7:0] pin
);
	// ****************************************
	// wire resolution
	// ****************************************
	// board pull-ups: a line nobody drives reads high, never a stale value
	always_comb begin
		pin = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_val) | (~dev_oe & ~ext_oe);
	end
endmodule : tvio_board
`default_nettype wire

// ==== tvio_ports_props.sv ====
// tvio_ports_props: concurrent checks on the port block's pins
`timescale 1ns/1ps
`default_nettype none
module tvio_ports_props (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic [7:0] first_port_lines_out,
	input wire logic [7:0] first_port_lines_oe,
	input wire logic [7:0] first_port_lines_pull_en,
	input wire logic [7:0] second_port_lines_out,
	input wire logic [7:0] second_port_lines_oe,
	input wire logic [7:0] second_port_lines_pull_en,
	input wire logic [7:0] third_port_lines_in,
	input wire logic [7:0] third_port_lines_out,
	input wire logic [7:0] third_port_lines_oe,
	input wire logic [7:0] third_port_lines_pull_en,
	input wire logic       serial_clock_drive,
	input wire logic       serial_enable_line_drive,
	input wire logic       serial_clock_sense,
	input wire logic       power_event_interrupt,
	input wire logic       remote_input_interrupt,
	input wire logic       irq,
	input wire logic       osc_enable,
	input wire logic       program_restart
);
	// ****************************************
	// helpers and checks
	// ****************************************
	logic       clr_pwr;
	logic [2:0] up_cnt;
	assign clr_pwr = reg_wr && reg_addr == tvio_pkg::OFS_IRQ_CLR && reg_wdata[0];
	// sense compare needs three settled cycles of pin history
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			up_cnt <= 3'h0;
		end else if (up_cnt != 3'h4) begin
			up_cnt <= up_cnt + 3'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_PA_OPEN_DRAIN: assert property (first_port_lines_out[7:4] == 4'h0 &&
		first_port_lines_pull_en[7:4] == 4'h0) else $error("first port upper lines misdriven");
	AST_PB_GAPS: assert property (((second_port_lines_out | second_port_lines_oe |
		second_port_lines_pull_en) & 8'h88) == 8'h00) else $error("second port gap driven");
	AST_PC_OPEN_DRAIN: assert property (third_port_lines_out == 8'h00 &&
		third_port_lines_pull_en[7:4] == 4'h0) else $error("third port not open-drain");
	AST_PULL_INPUT: assert property (((first_port_lines_pull_en & first_port_lines_oe) |
		(second_port_lines_pull_en & second_port_lines_oe)) == 8'h00)
		else $error("pull-up on while driving");
	AST_SER_SCL: assert property ($rose(third_port_lines_oe[0]) |->
		!$past(serial_clock_drive) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("clock line pulled low without cause");
	AST_SER_SEN: assert property ($rose(third_port_lines_oe[3]) |->
		!$past(serial_enable_line_drive) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("enable line pulled low without cause");
	AST_SENSE_SCL: assert property (up_cnt == 3'h4 |->
		serial_clock_sense == $past(third_port_lines_in[0], 3)) else $error("clock sense wrong");
	AST_IRQ_SRC: assert property (irq |-> power_event_interrupt || remote_input_interrupt)
		else $error("irq without status");
	AST_PWR_STICKY: assert property ($fell(power_event_interrupt) |->
		$past(clr_pwr) || $past(clr_pwr, 2)) else $error("power status lost without clear");
	AST_RESTART: assert property ($fell(reset) |=> osc_enable && program_restart)
		else $error("no restart after reset");
	AST_RUN_STEADY: assert property (!$past(reset) && !$past(reset, 2) |->
		osc_enable && !program_restart) else $error("oscillator or restart wrong in run");
	AST_RST_IDLE: assert property ($past(reset) |->
		(first_port_lines_oe | second_port_lines_oe | third_port_lines_oe) == 8'h00)
		else $error("line driven after reset");
endmodule : tvio_ports_props
`default_nettype wire

// ==== tvio_ports_test.sv ====
// tvio_ports_test: self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
module tvio_ports_test;
	logic       core_clk, reset, reg_wr, reg_rd, irq, pwr, rmt, osc, rst_go;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ext_v, ext_e, m;
	logic [7:0] pa_o, pa_e, pa_p, pa_n, pb_o, pb_e, pb_p, pb_n, pc_o, pc_e, pc_p, pc_n;
	logic [2:0] drv, sns, e3;
	logic [1:0] st;
	int         fail_count, tests_run, i;
	assign st = {rmt, pwr};
	tvio_ports uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.first_port_lines_in(pa_n), .first_port_lines_out(pa_o), .first_port_lines_oe(pa_e),
		.first_port_lines_pull_en(pa_p), .second_port_lines_in(pb_n),
		.second_port_lines_out(pb_o), .second_port_lines_oe(pb_e),
		.second_port_lines_pull_en(pb_p), .third_port_lines_in(pc_n),
		.third_port_lines_out(pc_o), .third_port_lines_oe(pc_e),
		.third_port_lines_pull_en(pc_p), .serial_clock_drive(drv[0]),
		.serial_data_drive(drv[1]), .serial_enable_line_drive(drv[2]),
		.serial_clock_sense(sns[0]), .serial_data_sense(sns[1]),
		.serial_enable_line_sense(sns[2]), .power_event_interrupt(pwr),
		.remote_input_interrupt(rmt), .irq(irq), .osc_enable(osc), .program_restart(rst_go));
	tvio_board u_pa (.dev_out(pa_o), .dev_oe(pa_e), .ext_val(8'h00), .ext_oe(8'h00), .pin(pa_n));
	tvio_board u_pb (.dev_out(pb_o), .dev_oe(pb_e), .ext_val(8'h00), .ext_oe(8'h00), .pin(pb_n));
	tvio_board u_pc (.dev_out(pc_o), .dev_oe(pc_e), .ext_val(ext_v), .ext_oe(ext_e), .pin(pc_n));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ****************************************
	// access and check tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rchk
	// long enough for drive, pin, two sync stages and sense register
	task automatic settle;
		repeat (6) @(posedge core_clk);
		#1;
	endtask : settle
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	task automatic wait_bit(input int b);
		int n;
		for (n = 0; n < 20 && st[b] !== 1'b1; n++) @(posedge core_clk);
		#1;
		if (n == 20) begin
			fail_count++;
			summarize();
		end
	endtask : wait_bit
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		ext_v = 8'h00;
		ext_e = 8'h00;
		drv = 3'h7;
		fail_count = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		settle();
		chk(pa_e | pb_e | pc_e, 8'h00);
		chk({7'h00, osc}, 8'h01);
		for (i = 0; i < 16; i++) if (i < 9 || i > 11) rchk(8'(i), 8'h00);
		rchk(8'h20, 8'h00);
		rchk(tvio_pkg::OFS_PB_PINS, 8'h77);
		$display("test reset done");
		wr(tvio_pkg::OFS_PA_DIR, 8'hff);
		wr(tvio_pkg::OFS_PA_DATA, 8'ha5);
		wr(tvio_pkg::OFS_PA_PULL, 8'hff);
		settle();
		chk(pa_o, 8'h05);
		chk(pa_e, 8'h5f);
		chk(pa_p, 8'h00);
		rchk(tvio_pkg::OFS_PA_PINS, 8'ha5);
		wr(tvio_pkg::OFS_PA_DIR, 8'h00);
		settle();
		chk(pa_e, 8'h00);
		chk(pa_p, 8'h0f);
		rchk(tvio_pkg::OFS_PA_PULL, 8'h0f);
		$display("test first port done");
		wr(tvio_pkg::OFS_PB_DIR, 8'hff);
		wr(tvio_pkg::OFS_PB_DATA, 8'hff);
		settle();
		chk(pb_o, 8'h77);
		chk(pb_e, 8'h77);
		wr(tvio_pkg::OFS_PB_DIR, 8'h00);
		wr(tvio_pkg::OFS_PB_PULL, 8'hff);
		settle();
		chk(pb_e, 8'h00);
		chk(pb_p, 8'h77);
		$display("test second port done");
		wr(tvio_pkg::OFS_PC_PULL, 8'hff);
		wr(tvio_pkg::OFS_PC_DIR, 8'hff);
		wr(tvio_pkg::OFS_PC_DATA, 8'hff);
		settle();
		chk(pc_o | pc_p | pc_e, 8'h00);
		m = 8'h00;
		for (i = 0; i < 3; i++) begin
			@(posedge core_clk);
			drv[i] <= 1'b0;
			m = m | (8'h01 << (i == 2 ? 3 : i));
			e3 = 3'h7 << (i + 1);
			settle();
			chk(pc_e, m);
			chk({5'h00, sns}, {5'h00, e3});
		end
		@(posedge core_clk);
		drv <= 3'h7;
		wr(tvio_pkg::OFS_PC_DATA, 8'h00);
		settle();
		chk(pc_e, 8'hff);
		wr(tvio_pkg::OFS_PC_DIR, 8'h00);
		settle();
		chk(pc_e, 8'h00);
		chk(pc_p, 8'h0f);
		$display("test third port done");
		@(posedge core_clk);
		ext_e <= 8'h50;
		ext_v <= 8'h40;
		settle();
		wr(tvio_pkg::OFS_EDGE_CFG, 8'h07);
		wr(tvio_pkg::OFS_IRQ_EN, 8'h03);
		wr(tvio_pkg::OFS_IRQ_STAT, 8'hff);
		rchk(tvio_pkg::OFS_IRQ_STAT, 8'h00);
		ext_v[4] <= 1'b1;
		wait_bit(0);
		chk({7'h00, irq}, 8'h01);
		rchk(tvio_pkg::OFS_IRQ_STAT, 8'h01);
		wr(tvio_pkg::OFS_IRQ_EN, 8'h00);
		settle();
		chk({7'h00, irq}, 8'h00);
		wr(tvio_pkg::OFS_IRQ_EN, 8'h03);
		wr(tvio_pkg::OFS_IRQ_CLR, 8'h01);
		settle();
		chk({5'h00, st, irq}, 8'h00);
		ext_v[6] <= 1'b0;
		wait_bit(1);
		rchk(tvio_pkg::OFS_IRQ_STAT, 8'h02);
		wr(tvio_pkg::OFS_IRQ_CLR, 8'h02);
		wr(tvio_pkg::OFS_EDGE_CFG, 8'h00);
		ext_v[4] <= 1'b0;
		settle();
		ext_v[4] <= 1'b1;
		settle();
		rchk(tvio_pkg::OFS_IRQ_STAT, 8'h00);
		$display("test edge interrupts done");
		summarize();
	end
endmodule : tvio_ports_test
bind tvio_ports tvio_ports_props u_props (.core_clk(core_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.first_port_lines_out(first_port_lines_out), .first_port_lines_oe(first_port_lines_oe),
	.first_port_lines_pull_en(first_port_lines_pull_en),
	.second_port_lines_out(second_port_lines_out), .second_port_lines_oe(second_port_lines_oe),
	.second_port_lines_pull_en(second_port_lines_pull_en),
	.third_port_lines_in(third_port_lines_in), .third_port_lines_out(third_port_lines_out),
	.third_port_lines_oe(third_port_lines_oe),
	.third_port_lines_pull_en(third_port_lines_pull_en),
	.serial_clock_drive(serial_clock_drive), .serial_enable_line_drive(serial_enable_line_drive),
	.serial_clock_sense(serial_clock_sense), .power_event_interrupt(power_event_interrupt),
	.remote_input_interrupt(remote_input_interrupt), .irq(irq), .osc_enable(osc_enable),
	.program_restart(program_restart));
`default_nettype wire
